// file: logic/fpd_map.svh
// register map and timing figures
`ifndef FPD_MAP_SVH
`define FPD_MAP_SVH

`define FPD_ADDR_W 8
`define FPD_ADDR_CTRL 8'h00
`define FPD_ADDR_SETPOINT 8'h04
`define FPD_ADDR_ASSIGN 8'h08
`define FPD_ADDR_MONSEL 8'h0C
`define FPD_ADDR_SETUP 8'h10
`define FPD_ADDR_STATUS 8'h14

`define FPD_CTRL_RUN 0
`define FPD_CTRL_MANUAL 1
`define FPD_CTRL_COMMS 2
`define FPD_CTRL_REMOTE 3
`define FPD_CTRL_PROTECT 4
`define FPD_CTRL_UNIT_F 5
`define FPD_CTRL_BAR_HEATER 6
`define FPD_CTRL_THIRD 10:8
`define FPD_CTRL_RST 11'h000

`define FPD_ASSIGN_AUX 15:0
`define FPD_ASSIGN_OUT 23:16
`define FPD_AUX_ASSIGN_RST 16'h4321
`define FPD_AUX_ASSIGN_HB_RST 16'h4328
`define FPD_OUT_ASSIGN_RST 8'h00
`define FPD_CODE_W 4

`define FPD_MON_ENABLE 0
`define FPD_MON_ITEM 15:8
`define FPD_MON_RST 16'h0000

`define FPD_SETUP_INTYPE 3:0
`define FPD_SETUP_CMODE 5:4
`define FPD_SETUP_ALTYPE 11:8
`define FPD_SETUP_AL1_EN 12
`define FPD_SETUP_AL1_VIS 13

`define FPD_STAT_LAMPTEST 0
`define FPD_STAT_RUNNING 1
`define FPD_STAT_FLASH 2
`define FPD_STAT_AUX 11:8
`define FPD_STAT_OUT 13:12

`define FPD_DEF_INPUT_TYPE 4'h5
`define FPD_DEF_CTRL_MODE 2'h0
`define FPD_DEF_ALARM_TYPE 4'h2
`define FPD_DEF_SETPOINT 16'h0000

`define FPD_FUNC_ALARM1 4'h1

`define FPD_REF_CLK_KHZ 100000
`define FPD_LAMP_TEST_MS 1000
`define FPD_FLASH_HALF_MS 250
`define FPD_STRAP_SETTLE 2'h2

`endif

// file: logic/fpd_pkg.sv
// types shared by the front panel display logic
package fpd_pkg;
    typedef enum logic [2:0] {
        THIRD_MV,
        THIRD_SOAK,
        THIRD_BANK,
        THIRD_RAMP_SP,
        THIRD_ALARM1
    } fpd_third_sel_type;

    typedef enum logic {
        PH_LAMP_TEST,
        PH_OPERATE
    } fpd_phase_type;
endpackage

// file: logic/fpd_timing_if.sv
// lamp test and flash timing carried from the timer to the panel
`timescale 1ns/100ps
interface fpd_timing_if;
    logic lampTest;
    logic flashPhase;
    modport source (output lampTest, output flashPhase);
    modport sink (input lampTest, input flashPhase);
endinterface

// file: logic/fpd_panel_timer.sv
// power-up lamp test timer and shared flash divider
`timescale 1ns/100ps
`include "fpd_map.svh"
module fpd_panel_timer #(
    parameter int LAMP_TEST_CYCLES = 1,
    parameter int FLASH_HALF_CYCLES = 1
) (
    input wire logic ref_clk,
    input wire logic rst,
    fpd_timing_if.source tim
);
    localparam int LT_W = $clog2(LAMP_TEST_CYCLES + 1);
    localparam int FL_W = $clog2(FLASH_HALF_CYCLES + 1);
    localparam logic [LT_W-1:0] LT_LAST = LT_W'(LAMP_TEST_CYCLES - 1);
    localparam logic [FL_W-1:0] FL_LAST = FL_W'(FLASH_HALF_CYCLES - 1);

    logic [LT_W-1:0] lampCnt;
    logic [FL_W-1:0] flashCnt;
    logic lampTest;
    logic flashPhase;

    wire lampDone = (lampCnt == LT_LAST);
    wire flashWrap = (flashCnt == FL_LAST);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            lampCnt <= '0;
            lampTest <= 1'b1;
        end else if (lampTest) begin
            lampCnt <= lampCnt + LT_W'(1);
            lampTest <= !lampDone;
        end
    end

    // one shared divider keeps lamps in phase
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            flashCnt <= '0;
            flashPhase <= 1'b0;
        end else begin
            flashCnt <= flashWrap ? '0 : flashCnt + FL_W'(1);
            flashPhase <= flashPhase ^ flashWrap;
        end
    end

    assign tim.lampTest = lampTest;
    assign tim.flashPhase = flashPhase;
endmodule

// file: logic/fpd_panel_top.sv
// front panel lamps, displays and operating defaults of the controller
`timescale 1ns/100ps
`include "fpd_map.svh"
//
// Contract
// - control runs at power-up unless the stop strap is set
// - defaults: input type 5, PID, upper-limit alarm, set point 0
// - heater detection: aux 1 heater alarm, alarm 1 off
// - all lamps and displays lit about 1 s after power-up
// - operate: process value upper, set point lower
// - upper shows process value or monitor item
// - lower shows set point or item value
// - third display shows one of five selected values
// - unit lamp shows C or F
// - aux lamp lit while its function is on
// - control lamp follows function; linear below 0% dark
// - comms write lamp while comms writing enabled
// - manual lamp in manual mode
// - stop lamp while stopped
// - tuning lamp during any tuning or filter adjust
// - remote lamp steady in remote set point mode
// - remote lamp flashes on remote input error
// - adaptive lamp flashes or lit during adaptive control
// - protect lamp while protection on
// - bar shows manipulated value or heater current
module fpd_panel_top #(
    parameter int DISP_W = 16,
    parameter int FUNC_N = 16,
    parameter int AUX_N = 4,
    parameter int CTRL_N = 2,
    parameter int LAMP_TEST_CYCLES =
        `FPD_LAMP_TEST_MS * `FPD_REF_CLK_KHZ,
    parameter int FLASH_HALF_CYCLES =
        `FPD_FLASH_HALF_MS * `FPD_REF_CLK_KHZ,
    parameter bit HEATER_DETECT_FITTED = 1'b0
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [`FPD_ADDR_W-1:0] regAddr,
    input wire logic [31:0] regWriteData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regReadData,
    input wire logic powerOnStopPin,
    input wire logic [FUNC_N-1:0] functionActive,
    input wire logic [CTRL_N-1:0] controlLinear,
    input wire logic [CTRL_N*DISP_W-1:0] controlOutLevel,
    input wire logic autotuning,
    input wire logic disturbanceAutotuning,
    input wire logic filterAdjusting,
    input wire logic rspInputError,
    input wire logic adaptiveActive,
    input wire logic adaptiveSettled,
    input wire logic [DISP_W-1:0] processValue,
    input wire logic [DISP_W-1:0] itemValue,
    input wire logic [DISP_W-1:0] manipulatedValue,
    input wire logic [DISP_W-1:0] soakRemaining,
    input wire logic [DISP_W-1:0] bankNumber,
    input wire logic [DISP_W-1:0] rampSetPoint,
    input wire logic [DISP_W-1:0] alarmValue1,
    input wire logic [DISP_W-1:0] heaterCurrent,
    output logic [DISP_W-1:0] upperDisplay,
    output logic [DISP_W-1:0] lowerDisplay,
    output logic [DISP_W-1:0] thirdDisplay,
    output logic [DISP_W-1:0] barDisplay,
    output logic unitCelsiusLamp,
    output logic unitFahrenheitLamp,
    output logic [AUX_N-1:0] auxOutputLamp,
    output logic [CTRL_N-1:0] controlOutputLamp,
    output logic commsWriteLamp,
    output logic manualModeLamp,
    output logic stopLamp,
    output logic tuningLamp,
    output logic remoteSetpointLamp,
    output logic adaptiveLamp,
    output logic protectLamp,
    output logic controlRun
);
    localparam int CW = `FPD_CODE_W;
    localparam logic [15:0] AUX_RST = HEATER_DETECT_FITTED ?
        `FPD_AUX_ASSIGN_HB_RST : `FPD_AUX_ASSIGN_RST;

    // function picked by a code is on
    function automatic logic fnOn(input logic [FUNC_N-1:0] act,
                                  input logic [CW-1:0] code);
        fnOn = (int'(code) < FUNC_N) ? act[code] : 1'b0;
    endfunction

    fpd_timing_if tim ();

    fpd_panel_timer #(
        .LAMP_TEST_CYCLES(LAMP_TEST_CYCLES),
        .FLASH_HALF_CYCLES(FLASH_HALF_CYCLES)
    ) u_timer (
        .ref_clk(ref_clk),
        .rst(rst),
        .tim(tim)
    );

    // bus
    wire wrCtrl = regWrite && (regAddr == `FPD_ADDR_CTRL);
    wire wrSetPoint = regWrite && (regAddr == `FPD_ADDR_SETPOINT);
    wire wrAssign = regWrite && (regAddr == `FPD_ADDR_ASSIGN);
    wire wrMonSel = regWrite && (regAddr == `FPD_ADDR_MONSEL);

    logic [10:0] ctrl;
    logic [DISP_W-1:0] setPoint;
    logic [15:0] auxAssign;
    logic [7:0] outAssign;
    logic [15:0] monSel;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctrl <= `FPD_CTRL_RST;
            setPoint <= DISP_W'(`FPD_DEF_SETPOINT);
            monSel <= `FPD_MON_RST;
        end else begin
            if (wrCtrl)
                ctrl <= regWriteData[10:0];
            if (wrSetPoint)
                setPoint <= regWriteData[DISP_W-1:0];
            if (wrMonSel)
                monSel <= regWriteData[15:0];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            auxAssign <= AUX_RST;
            outAssign <= `FPD_OUT_ASSIGN_RST;
        end else if (wrAssign) begin
            auxAssign <= regWriteData[`FPD_ASSIGN_AUX];
            outAssign <= regWriteData[`FPD_ASSIGN_OUT];
        end
    end

    wire manualMode = ctrl[`FPD_CTRL_MANUAL];
    wire commsWrite = ctrl[`FPD_CTRL_COMMS];
    wire remoteSp = ctrl[`FPD_CTRL_REMOTE];
    wire protectOn = ctrl[`FPD_CTRL_PROTECT];
    wire unitF = ctrl[`FPD_CTRL_UNIT_F];
    wire barHeater = ctrl[`FPD_CTRL_BAR_HEATER];
    wire monEnable = monSel[`FPD_MON_ENABLE];
    wire [7:0] monItem = monSel[`FPD_MON_ITEM];
    fpd_pkg::fpd_third_sel_type thirdSel;
    assign thirdSel = fpd_pkg::fpd_third_sel_type'(ctrl[`FPD_CTRL_THIRD]);

    // run strap
    // pin: two stages, taken after release
    logic strapMeta;
    logic strapSync;
    logic [1:0] settleCnt;
    logic strapDone;
    logic running;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            strapMeta <= 1'b0;
            strapSync <= 1'b0;
        end else begin
            strapMeta <= powerOnStopPin;
            strapSync <= strapMeta;
        end
    end

    wire strapTake = !strapDone && (settleCnt == `FPD_STRAP_SETTLE);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            settleCnt <= '0;
            strapDone <= 1'b0;
        end else if (!strapDone) begin
            settleCnt <= settleCnt + 2'h1;
            strapDone <= strapTake;
        end
    end

    // strap beats a same-cycle write
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst)
            running <= 1'b0;
        else if (strapTake)
            running <= !strapSync;
        else if (wrCtrl && strapDone)
            running <= regWriteData[`FPD_CTRL_RUN];
    end

    // alarm 1
    logic [AUX_N-1:0] alarm1Hit;
    logic [AUX_N-1:0] auxRaw;
    logic [CTRL_N-1:0] outRaw;

    genvar gi;
    generate
        for (gi = 0; gi < AUX_N; gi++) begin : g_aux
            wire [CW-1:0] code = auxAssign[gi*CW +: CW];
            assign alarm1Hit[gi] = (code == `FPD_FUNC_ALARM1);
            assign auxRaw[gi] = fnOn(functionActive, code);
        end
        for (gi = 0; gi < CTRL_N; gi++) begin : g_out
            wire [CW-1:0] code = outAssign[gi*CW +: CW];
            wire belowZero = controlOutLevel[gi*DISP_W + DISP_W - 1];
            // linear below 0% stays dark
            assign outRaw[gi] = fnOn(functionActive, code) &&
                !(controlLinear[gi] && belowZero);
        end
    endgenerate

    wire alarm1Enabled = |alarm1Hit;

    // lamp test, then operate
    fpd_pkg::fpd_phase_type phase;
    fpd_pkg::fpd_phase_type next_phase;

    always_comb begin
        next_phase = phase;
        unique case (phase)
            fpd_pkg::PH_LAMP_TEST: begin
                if (!tim.lampTest)
                    next_phase = fpd_pkg::PH_OPERATE;
            end
            fpd_pkg::PH_OPERATE: begin
                next_phase = fpd_pkg::PH_OPERATE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst)
            phase <= fpd_pkg::PH_LAMP_TEST;
        else
            phase <= next_phase;
    end

    wire testOn = (phase == fpd_pkg::PH_LAMP_TEST);
    wire flash = tim.flashPhase;

    // displays
    logic [DISP_W-1:0] thirdRaw;

    always_comb begin
        unique case (thirdSel)
            fpd_pkg::THIRD_MV: thirdRaw = manipulatedValue;
            fpd_pkg::THIRD_SOAK: thirdRaw = soakRemaining;
            fpd_pkg::THIRD_BANK: thirdRaw = bankNumber;
            fpd_pkg::THIRD_RAMP_SP: thirdRaw = rampSetPoint;
            fpd_pkg::THIRD_ALARM1: thirdRaw = alarmValue1;
            default: thirdRaw = manipulatedValue;
        endcase
    end

    wire [DISP_W-1:0] upperRaw =
        monEnable ? DISP_W'(monItem) : processValue;
    wire [DISP_W-1:0] lowerRaw =
        monEnable ? itemValue : setPoint;
    wire [DISP_W-1:0] barRaw =
        barHeater ? heaterCurrent : manipulatedValue;

    wire [DISP_W-1:0] next_upper = testOn ? '1 : upperRaw;
    wire [DISP_W-1:0] next_lower = testOn ? '1 : lowerRaw;
    wire [DISP_W-1:0] next_third = testOn ? '1 : thirdRaw;
    wire [DISP_W-1:0] next_bar = testOn ? '1 : barRaw;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            upperDisplay <= '0;
            lowerDisplay <= '0;
            thirdDisplay <= '0;
            barDisplay <= '0;
        end else begin
            upperDisplay <= next_upper;
            lowerDisplay <= next_lower;
            thirdDisplay <= next_third;
            barDisplay <= next_bar;
        end
    end

    // lamps
    wire tuneRaw = autotuning || disturbanceAutotuning ||
        filterAdjusting;
    // blinks on a remote input error
    wire rspRaw = remoteSp && (!rspInputError || flash);
    // steady once settled, else blinks
    wire adaptRaw = adaptiveActive &&
        (adaptiveSettled || flash);

    wire [AUX_N-1:0] next_aux = testOn ? '1 : auxRaw;
    wire [CTRL_N-1:0] next_out = testOn ? '1 : outRaw;
    wire next_celsius = testOn || !unitF;
    wire next_fahrenheit = testOn || unitF;
    wire next_comms = testOn || commsWrite;
    wire next_manual = testOn || manualMode;
    wire next_stop = testOn || !running;
    wire next_tune = testOn || tuneRaw;
    wire next_rsp = testOn || rspRaw;
    wire next_adapt = testOn || adaptRaw;
    wire next_protect = testOn || protectOn;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            auxOutputLamp <= '0;
            controlOutputLamp <= '0;
            unitCelsiusLamp <= 1'b0;
            unitFahrenheitLamp <= 1'b0;
        end else begin
            auxOutputLamp <= next_aux;
            controlOutputLamp <= next_out;
            unitCelsiusLamp <= next_celsius;
            unitFahrenheitLamp <= next_fahrenheit;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            commsWriteLamp <= 1'b0;
            manualModeLamp <= 1'b0;
            stopLamp <= 1'b0;
            tuningLamp <= 1'b0;
            remoteSetpointLamp <= 1'b0;
            adaptiveLamp <= 1'b0;
            protectLamp <= 1'b0;
        end else begin
            commsWriteLamp <= next_comms;
            manualModeLamp <= next_manual;
            stopLamp <= next_stop;
            tuningLamp <= next_tune;
            remoteSetpointLamp <= next_rsp;
            adaptiveLamp <= next_adapt;
            protectLamp <= next_protect;
        end
    end

    // control runs during lamp test
    assign controlRun = running;

    // read path
    logic [31:0] setupWord;
    logic [31:0] statusWord;
    logic [31:0] next_read;

    always_comb begin
        setupWord = '0;
        setupWord[`FPD_SETUP_INTYPE] = `FPD_DEF_INPUT_TYPE;
        setupWord[`FPD_SETUP_CMODE] = `FPD_DEF_CTRL_MODE;
        setupWord[`FPD_SETUP_ALTYPE] = `FPD_DEF_ALARM_TYPE;
        setupWord[`FPD_SETUP_AL1_EN] = alarm1Enabled;
        // type hidden until an aux output carries alarm 1
        setupWord[`FPD_SETUP_AL1_VIS] = alarm1Enabled;
    end

    always_comb begin
        statusWord = '0;
        statusWord[`FPD_STAT_LAMPTEST] = testOn;
        statusWord[`FPD_STAT_RUNNING] = running;
        statusWord[`FPD_STAT_FLASH] = flash;
        statusWord[`FPD_STAT_AUX] = auxRaw;
        statusWord[`FPD_STAT_OUT] = outRaw;
    end

    always_comb begin
        next_read = '0;
        if (regRead) begin
            unique case (regAddr)
                `FPD_ADDR_CTRL: begin
                    next_read = 32'(ctrl);
                    next_read[`FPD_CTRL_RUN] = running;
                end
                `FPD_ADDR_SETPOINT: next_read = 32'(setPoint);
                `FPD_ADDR_ASSIGN: next_read = {8'h00, outAssign, auxAssign};
                `FPD_ADDR_MONSEL: next_read = 32'(monSel);
                `FPD_ADDR_SETUP: next_read = setupWord;
                `FPD_ADDR_STATUS: next_read = statusWord;
                default: next_read = '0;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst)
            regReadData <= '0;
        else
            regReadData <= next_read;
    end
endmodule

// file: test/fpd_panel_properties.sv
// concurrent checks on the front panel top ports
`timescale 1ns/100ps
`include "fpd_map.svh"
module fpd_panel_properties #(
    parameter int DISP_W = 16,
    parameter int FUNC_N = 16,
    parameter int AUX_N = 4,
    parameter int LAMP_TEST_CYCLES = 20
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [`FPD_ADDR_W-1:0] regAddr,
    input wire logic [31:0] regWriteData,
    input wire logic regWrite,
    input wire logic [FUNC_N-1:0] functionActive,
    input wire logic autotuning,
    input wire logic disturbanceAutotuning,
    input wire logic filterAdjusting,
    input wire logic rspInputError,
    input wire logic adaptiveActive,
    input wire logic adaptiveSettled,
    input wire logic [DISP_W-1:0] processValue,
    input wire logic [DISP_W-1:0] manipulatedValue,
    input wire logic [DISP_W-1:0] heaterCurrent,
    input wire logic [DISP_W-1:0] upperDisplay,
    input wire logic [DISP_W-1:0] barDisplay,
    input wire logic unitCelsiusLamp,
    input wire logic unitFahrenheitLamp,
    input wire logic [AUX_N-1:0] auxOutputLamp,
    input wire logic commsWriteLamp,
    input wire logic manualModeLamp,
    input wire logic stopLamp,
    input wire logic tuningLamp,
    input wire logic remoteSetpointLamp,
    input wire logic adaptiveLamp,
    input wire logic protectLamp
);
    int age;
    logic [6:0] ctrl;
    logic monOn;
    logic settled;
    logic inTest;
    assign settled = age >= LAMP_TEST_CYCLES + 4;
    assign inTest = age >= 2 && age <= LAMP_TEST_CYCLES - 2;
    // mode bit mirror
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            age <= 0;
            ctrl <= 7'h00;
            monOn <= 1'b0;
        end else begin
            if (!settled) age <= age + 1;
            if (regWrite && regAddr == `FPD_ADDR_CTRL) ctrl <= regWriteData[6:0];
            if (regWrite && regAddr == `FPD_ADDR_MONSEL) monOn <= regWriteData[0];
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    lamp_test_a: assert property (
        inTest |-> &upperDisplay && &auxOutputLamp && tuningLamp && stopLamp)
        else $error("lamp dark in test");
    tune_lamp_a: assert property (
        settled |=> tuningLamp ==
            $past(autotuning || disturbanceAutotuning || filterAdjusting))
        else $error("tuning lamp wrong");
    // aux map stays 1..4
    aux_lamp_a: assert property (
        settled |=> auxOutputLamp == $past(functionActive[4:1]))
        else $error("aux lamps wrong");
    upper_disp_a: assert property (
        settled && !monOn |=> upperDisplay == $past(processValue))
        else $error("upper display wrong");
    mode_lamps_a: assert property (
        settled |=> manualModeLamp == $past(ctrl[1]) &&
            commsWriteLamp == $past(ctrl[2]) && protectLamp == $past(ctrl[4]))
        else $error("mode lamp wrong");
    unit_lamp_a: assert property (
        settled |=> unitFahrenheitLamp == $past(ctrl[5]) &&
            unitCelsiusLamp != unitFahrenheitLamp)
        else $error("unit lamps wrong");
    bar_disp_a: assert property (
        settled |=> barDisplay == ($past(ctrl[6]) ?
            $past(heaterCurrent) : $past(manipulatedValue)))
        else $error("bar wrong");
    remote_steady_a: assert property (
        settled && !rspInputError |=> remoteSetpointLamp == $past(ctrl[3]))
        else $error("remote lamp wrong");
    flash_phase_a: assert property (
        settled && $past(ctrl[3] && rspInputError && adaptiveActive &&
            !adaptiveSettled) |-> remoteSetpointLamp == adaptiveLamp)
        else $error("flash out of phase");
    // 7 exceeds a half period of 4
    flash_rate_a: assert property (
        not ((settled && ctrl[3] && rspInputError &&
            $stable(remoteSetpointLamp)) [*7]))
        else $error("remote lamp not flashing");
endmodule
bind fpd_panel_top fpd_panel_properties #(.DISP_W(DISP_W),
    .FUNC_N(FUNC_N), .AUX_N(AUX_N), .LAMP_TEST_CYCLES(LAMP_TEST_CYCLES)
) props (.*);

// file: test/fpd_lamp_panel_model.sv
// panel model: counts visible changes of the two flashing lamps
`timescale 1ns/100ps
module fpd_lamp_panel_model (
    input wire logic ref_clk,
    input wire logic clear,
    input wire logic remoteSetpointLamp,
    input wire logic adaptiveLamp,
    output logic [7:0] rspFlips,
    output logic [7:0] adpFlips
);
    logic lastRsp;
    logic lastAdp;
    // sampled per edge: glitches never count
    always_ff @(posedge ref_clk) begin
        lastRsp <= remoteSetpointLamp;
        lastAdp <= adaptiveLamp;
        if (clear) begin
            rspFlips <= 8'h00;
            adpFlips <= 8'h00;
        end else begin
            if (remoteSetpointLamp != lastRsp) rspFlips <= rspFlips + 8'h01;
            if (adaptiveLamp != lastAdp) adpFlips <= adpFlips + 8'h01;
        end
    end
endmodule

// file: test/fpd_panel_top_bench.sv
// self-checking bench for the front panel top
`timescale 1ns/100ps
`include "fpd_map.svh"
module fpd_panel_top_bench;
    typedef struct packed {
        logic [10:0] ctrl;
        logic mon;
        logic [2:0] tune;
        logic [7:0] func;
        logic [15:0] sel;
        logic [7:0] lamps;
        logic [3:0] aux;
        logic [1:0] ctl;
    } fpd_row_type;
    // sel: dv index per display; 8 set point, 9 item code
    fpd_row_type rows [0:5] = '{
        '{11'h001, 1'b0, 3'h0, 8'h02, 16'h0822, 8'h80, 4'h1, 2'h0},
        '{11'h167, 1'b0, 3'h0, 8'h34, 16'h0837, 8'h70, 4'hA, 2'h1},
        '{11'h219, 1'b1, 3'h1, 8'h40, 16'h9142, 8'h8E, 4'h0, 2'h2},
        '{11'h300, 1'b0, 3'h2, 8'h7E, 16'h0852, 8'h83, 4'hF, 2'h3},
        '{11'h401, 1'b0, 3'h4, 8'h01, 16'h0862, 8'h82, 4'h0, 2'h0},
        '{11'h701, 1'b0, 3'h0, 8'h08, 16'h0822, 8'h80, 4'h4, 2'h0}};
    logic [35:0] linCase [0:3] = '{{2'b01, 32'h0100_8000, 2'b10},
        {2'b01, 32'h0100_0001, 2'b11}, {2'b00, 32'h8000_8000, 2'b11},
        {2'b10, 32'h8000_0100, 2'b01}};
    logic ref_clk, rst, regWrite, regRead, powerOnStopPin, modelClear;
    logic [7:0] regAddr;
    logic [31:0] regWriteData, regReadData, controlOutLevel;
    logic [15:0] functionActive;
    logic [1:0] controlLinear, controlOutputLamp;
    logic [2:0] tune, flg;
    logic [15:0] dv [0:9];
    logic [15:0] upperDisplay, lowerDisplay, thirdDisplay, barDisplay;
    logic [3:0] auxOutputLamp;
    logic unitCelsiusLamp, unitFahrenheitLamp, commsWriteLamp, manualModeLamp;
    logic stopLamp, tuningLamp, remoteSetpointLamp, adaptiveLamp, protectLamp;
    logic controlRun;
    logic [7:0] rspFlips, adpFlips, lampVec;
    int errors, checks;
    assign lampVec = {unitCelsiusLamp, unitFahrenheitLamp, commsWriteLamp,
        manualModeLamp, remoteSetpointLamp, protectLamp, tuningLamp, stopLamp};
    fpd_panel_top #(.LAMP_TEST_CYCLES(20), .FLASH_HALF_CYCLES(4)) dut (
        .ref_clk, .rst, .regAddr, .regWriteData, .regWrite, .regRead,
        .regReadData, .powerOnStopPin, .functionActive, .controlLinear,
        .controlOutLevel, .autotuning(tune[0]),
        .disturbanceAutotuning(tune[1]), .filterAdjusting(tune[2]),
        .rspInputError(flg[2]), .adaptiveActive(flg[1]),
        .adaptiveSettled(flg[0]), .processValue(dv[0]), .itemValue(dv[1]),
        .manipulatedValue(dv[2]), .soakRemaining(dv[3]), .bankNumber(dv[4]),
        .rampSetPoint(dv[5]), .alarmValue1(dv[6]), .heaterCurrent(dv[7]),
        .upperDisplay, .lowerDisplay, .thirdDisplay, .barDisplay,
        .unitCelsiusLamp, .unitFahrenheitLamp, .auxOutputLamp,
        .controlOutputLamp, .commsWriteLamp, .manualModeLamp, .stopLamp,
        .tuningLamp, .remoteSetpointLamp, .adaptiveLamp, .protectLamp,
        .controlRun);
    fpd_lamp_panel_model panel (.ref_clk, .clear(modelClear),
        .remoteSetpointLamp, .adaptiveLamp, .rspFlips, .adpFlips);
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regWriteData <= d;
        regWrite <= 1'b1;
        @(posedge ref_clk);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge ref_clk);
        regRead <= 1'b0;
        #1;
        chk(regReadData, exp);
    endtask
    task automatic wait_cycles(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic do_reset(input logic strap);
        rst <= 1'b1;
        powerOnStopPin <= strap;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        rst = 1'b1;
        regAddr = 8'h00;
        regWriteData = 32'h0000_0000;
        regWrite = 1'b0;
        regRead = 1'b0;
        functionActive = 16'h0000;
        controlLinear = 2'h0;
        controlOutLevel = 32'h0000_0000;
        tune = 3'h0;
        flg = 3'h0;
        modelClear = 1'b1;
        for (int k = 0; k < 8; k++) dv[k] = {4'(k), 12'hA5A};
        dv[8] = 16'h0ABC;
        dv[9] = 16'h0042;
        do_reset(1'b0);
        wait_cycles(6);
        chk({upperDisplay, lowerDisplay}, 32'hFFFF_FFFF);
        chk({thirdDisplay, barDisplay}, 32'hFFFF_FFFF);
        chk({adaptiveLamp, lampVec, auxOutputLamp, controlOutputLamp}, 32'h7FFF);
        wait_cycles(24);
        $display("test lamp_test done");
        chk(controlRun, 1'b1);
        chk({upperDisplay, lowerDisplay}, {dv[0], 16'h0000});
        rd(`FPD_ADDR_SETUP, 32'h0000_3205);
        wr(`FPD_ADDR_SETUP, 32'h0000_0000);
        rd(`FPD_ADDR_SETUP, 32'h0000_3205);
        rd(8'h20, 32'h0000_0000);
        $display("test defaults done");
        wr(`FPD_ADDR_SETPOINT, 32'h0000_0ABC);
        wr(`FPD_ADDR_ASSIGN, 32'h0065_4321);
        rd(`FPD_ADDR_ASSIGN, 32'h0065_4321);
        foreach (rows[i]) begin
            @(posedge ref_clk);
            for (int k = 0; k < 8; k++) dv[k] <= {4'(k), 4'(i), 8'hA5};
            functionActive <= {8'h00, rows[i].func};
            tune <= rows[i].tune;
            wr(`FPD_ADDR_CTRL, {21'h0, rows[i].ctrl});
            wr(`FPD_ADDR_MONSEL, {16'h0, 8'h42, 7'h0, rows[i].mon});
            wait_cycles(3);
            chk({lampVec, auxOutputLamp, controlOutputLamp}, {rows[i].lamps, rows[i].aux, rows[i].ctl});
            chk({upperDisplay, lowerDisplay}, {dv[rows[i].sel[15:12]], dv[rows[i].sel[11:8]]});
            chk({thirdDisplay, barDisplay}, {dv[rows[i].sel[7:4]], dv[rows[i].sel[3:0]]});
            rd(`FPD_ADDR_CTRL, {21'h0, rows[i].ctrl});
        end
        $display("test table done");
        functionActive <= 16'h0060;
        for (int k = 0; k < 4; k++) begin
            @(posedge ref_clk);
            {controlLinear, controlOutLevel} <= linCase[k][35:2];
            wait_cycles(3);
            chk(controlOutputLamp, linCase[k][1:0]);
        end
        $display("test linear done");
        wr(`FPD_ADDR_CTRL, 32'h0000_0009);
        @(posedge ref_clk);
        flg <= 3'b110;
        wait_cycles(3);
        modelClear = 1'b0;
        wait_cycles(16);
        chk(rspFlips >= 8'h03 && rspFlips <= 8'h05, 1'b1);
        chk(adpFlips, rspFlips);
        @(posedge ref_clk);
        flg <= 3'b011;
        modelClear <= 1'b1;
        wait_cycles(3);
        modelClear = 1'b0;
        wait_cycles(8);
        chk({rspFlips, adpFlips}, 16'h0000);
        chk({remoteSetpointLamp, adaptiveLamp}, 2'b11);
        $display("test flash done");
        do_reset(1'b1);
        wait_cycles(30);
        chk({controlRun, stopLamp}, 2'b01);
        wr(`FPD_ADDR_CTRL, 32'h0000_0001);
        wait_cycles(3);
        chk({controlRun, stopLamp}, 2'b10);
        $display("test strap done");
        final_report;
    end
    initial begin
        repeat (5000) @(posedge ref_clk);
        errors++;
        final_report;
    end
endmodule
